// [psmb_host_model.sv]
// Host model: the single initiator on the two-wire bus, open-drain outputs.
// Assumes the bench resolves both lines with pull-ups; high means released.
`timescale 1ns/100ps
module psmb_host_model #(
  parameter int unsigned HALF_NS = 5000,
  parameter int unsigned GAP_NS  = 5_000_000
) (
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // Both lines released while idle, so SCL stands still between frames
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  // START or repeated START; returns with SCL held low
  task automatic start();
    sda_low = 1'h0;
    #(HALF_NS / 2) scl_low = 1'h0;
    #(HALF_NS) sda_low = 1'h1;
    #(HALF_NS) scl_low = 1'h1;
    #(HALF_NS / 2);
  endtask : start
  // One bit: data moves mid-low, sampled mid-high, never faster than 100 kbps
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #(HALF_NS / 2) scl_low = 1'h0;
    #(HALF_NS / 2) s = sda_line;
    #(HALF_NS / 2) scl_low = 1'h1;
    #(HALF_NS / 2);
  endtask : bit_io
  // Byte MSB first, so an address byte ends in its direction bit
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack);
  endtask : xfer
  // STOP; after an EEPROM write the bus stays free for the programming time
  task automatic stop(input logic after_write);
    sda_low = 1'h1;
    #(HALF_NS / 2) scl_low = 1'h0;
    #(HALF_NS) sda_low = 1'h0;
    #(after_write ? GAP_NS : HALF_NS);
  endtask : stop
endmodule : psmb_host_model

// [psmb_pkg.sv]
// Package for the supply's two-wire target block: codes, addresses, timing.
// Assumes a 20 MHz system clock and SCL rates up to 100 kbps.
package psmb_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ         = 20_000_000;
  // Bus timing figures in their own units
  localparam int unsigned STRETCH_MAX_US = 1000;
  localparam int unsigned TIMEOUT_MIN_MS = 25;
  localparam int unsigned RECOVER_MAX_MS = 10;
  localparam int unsigned STRETCH_CYC    = CLK_HZ / 1_000_000 * STRETCH_MAX_US;
  localparam int unsigned TIMEOUT_CYC    = CLK_HZ / 1000 * TIMEOUT_MIN_MS + 1;
  localparam int unsigned RECOVER_CYC    = CLK_HZ / 1000 * RECOVER_MAX_MS;
  // Seven-bit bus addresses, and the three-bit default select code
  localparam logic [6:0] CTRL_BASE_ADDR  = 7'h58;
  localparam logic [6:0] EEP_BASE_ADDR   = 7'h50;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [2:0] SEL_DEFAULT     = 3'h7;
  // Sizes
  localparam int unsigned EEP_BYTES      = 256;
  localparam int unsigned BLOCK_MAX      = 255;
  // Which device a transfer is aimed at
  typedef enum logic [1:0] {PSMB_TGT_NONE, PSMB_TGT_CTRL, PSMB_TGT_EEP, PSMB_TGT_ARA} psmb_tgt_t;
endpackage : psmb_pkg

// [psmb_sync.sv]
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps
module psmb_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // Chain; output moves only when second and third stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout   <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule : psmb_sync

// [psmb_target.sv]
// Two-wire target for the supply controller, user EEPROM and alert response.
// Assumes open-drain SDA/SCL resolved outside; select strap valid at reset.
`timescale 1ns/100ps
// Function
// - Device is only a target, never starts a transaction.
// - Works at bus rates up to 100 kbps.
// - Any clock stretch released within 1 ms.
// - SCL low over 25 ms aborts transfer; ready within 10 ms.
// - START and STOP detected anywhere, resetting the protocol machine.
// - Alert output low while any shutdown or warning event is present.
// - Read at alert response address 0x19 returns the status register.
// - Select code picks protocol and controller address 0xB0 to 0xB6.
// - EEPROM address is controller address with fixed offset, 0xBn to 0xAn.
// - Setting controller address assigns the matching EEPROM address.
// - Open select pin gives word register protocol at 0xB6/0xA6.
// - Selection sampled once after reset, then held.
// - Address byte LSB is direction, upper seven bits address.
// - EEPROM writes blocked while write protect set, set after reset.
// - EEPROM holds 256 user bytes.
// - EEPROM write: address write, memory address, data, STOP.
// - EEPROM read: address write, memory address, repeated START, address read.
// - Register protocol: one register per transaction, common format.
// - Register protocol carries no error checking byte.
// - Register protocol writes are 16-bit words only.
// - Register protocol reads return 16-bit words only.
// - PMBus block transfers up to 255 bytes.
module psmb_target
  import psmb_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [2:0] addr_proto_select,
  input  wire logic       shutdown_event,
  input  wire logic       warning_event,
  input  wire logic [7:0] status_value,
  input  wire logic       eep_wp_clear,
  input  wire logic       eep_wp_set,
  input  wire logic [15:0] ctrl_rd_data,
  output logic            fault_alert_n,
  output logic            word_register_protocol,
  output logic [6:0]      ctrl_addr,
  output logic            eep_wp,
  output logic            ctrl_wr_stb,
  output logic [7:0]      ctrl_cmd,
  output logic [15:0]     ctrl_wr_data,
  output logic            ctrl_byte_stb,
  output logic            bus_timeout
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_ACK_OUT, ST_ACK_IN} psmb_st_t;

  logic        scl_s;
  logic        sda_s;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  psmb_st_t    st_reg;
  psmb_tgt_t   tgt_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  nbyte_reg;
  logic        rd_reg;
  logic        sel_done_reg;
  logic [6:0]  eep_addr_reg;
  logic [7:0]  eep_ptr_reg;
  logic [7:0]  eep_data_reg;
  logic [7:0]  mem_reg [EEP_BYTES];
  logic [15:0] tx_word_reg;
  logic [24:0] low_cnt_reg;
  logic [24:0] rec_cnt_reg;
  logic        to_evt;

  // Pin inputs pass the three-flop filter
  psmb_sync u_scl (.mclk(mclk), .sys_rst(sys_rst), .din(scl_i), .dout(scl_s));
  psmb_sync u_sda (.mclk(mclk), .sys_rst(sys_rst), .din(sda_i), .dout(sda_s));

  // Edge and condition detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Address match for an address byte
  function automatic psmb_tgt_t match_addr(input logic [6:0] a, input logic [6:0] c,
                                           input logic [6:0] e);
    if (a == c) begin
      match_addr = PSMB_TGT_CTRL;
    end else if (a == e) begin
      match_addr = PSMB_TGT_EEP;
    end else if (a == ALERT_RESP_ADDR) begin
      match_addr = PSMB_TGT_ARA;
    end else begin
      match_addr = PSMB_TGT_NONE;
    end
  endfunction : match_addr

  // Strap capture once after reset; code bit 2 picks the word register protocol
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_done_reg           <= 1'b0;
      word_register_protocol <= 1'b1;
      ctrl_addr              <= CTRL_BASE_ADDR + 7'h03;
      eep_addr_reg           <= EEP_BASE_ADDR + 7'h03;
    end else if (!sel_done_reg) begin
      sel_done_reg           <= 1'b1;
      word_register_protocol <= addr_proto_select[2];
      ctrl_addr              <= CTRL_BASE_ADDR + {5'h00, addr_proto_select[1:0]};
      eep_addr_reg           <= EEP_BASE_ADDR + {5'h00, addr_proto_select[1:0]};
    end
  end

  // Alert is an OR of both event groups, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_alert_n <= 1'b1;
    end else begin
      fault_alert_n <= ~(shutdown_event | warning_event);
    end
  end

  // Write protect: on after reset, cleared by controller command
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eep_wp <= 1'b1;
    end else if (eep_wp_set) begin
      eep_wp <= 1'b1;
    end else if (eep_wp_clear) begin
      eep_wp <= 1'b0;
    end
  end

  // SCL low watchdog; recovery window keeps the machine idle for a bounded time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_cnt_reg <= 25'h0000000;
      rec_cnt_reg <= 25'h0000000;
      bus_timeout <= 1'b0;
    end else begin
      bus_timeout <= 1'b0;
      if (scl_s || st_reg == ST_IDLE) begin
        low_cnt_reg <= 25'h0000000;
      end else if (low_cnt_reg == 25'(TIMEOUT_CYCLES)) begin
        low_cnt_reg <= 25'h0000000;
        bus_timeout <= 1'b1;
      end else begin
        low_cnt_reg <= low_cnt_reg + 25'h0000001;
      end
      if (to_evt) begin
        rec_cnt_reg <= 25'(RECOVER_CYCLES / 2);
      end else if (rec_cnt_reg != 25'h0000000) begin
        rec_cnt_reg <= rec_cnt_reg - 25'h0000001;
      end
    end
  end
  assign to_evt = (low_cnt_reg == 25'(TIMEOUT_CYCLES)) && !scl_s && st_reg != ST_IDLE;

  // Byte engine; never stretches SCL and never initiates
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg        <= ST_IDLE;
      tgt_reg       <= PSMB_TGT_NONE;
      sh_reg        <= 8'h00;
      bit_reg       <= 4'h0;
      nbyte_reg     <= 8'h00;
      rd_reg        <= 1'b0;
      eep_ptr_reg   <= 8'h00;
      tx_word_reg   <= 16'h0000;
      sda_oe        <= 1'b0;
      ctrl_wr_stb   <= 1'b0;
      ctrl_byte_stb <= 1'b0;
      ctrl_cmd      <= 8'h00;
      ctrl_wr_data  <= 16'h0000;
    end else begin
      ctrl_wr_stb   <= 1'b0;
      ctrl_byte_stb <= 1'b0;
      if (to_evt || rec_cnt_reg != 25'h0000000) begin
        st_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        st_reg  <= ST_ADDR;
        bit_reg <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        if (st_reg != ST_IDLE && tgt_reg == PSMB_TGT_CTRL && !rd_reg) begin
          // Word protocol commits only a full word
          if (!word_register_protocol || nbyte_reg == 8'h04) begin
            ctrl_wr_stb <= 1'b1;
          end
        end
        st_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise && bit_reg != 4'h8) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (st_reg == ST_ADDR) begin
                tgt_reg   <= match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg);
                rd_reg    <= sh_reg[0];
                nbyte_reg <= 8'h00;
                tx_word_reg <= (match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg) == PSMB_TGT_ARA)
                               ? {status_value, 8'h00}
                               : ((match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg) == PSMB_TGT_EEP)
                                  ? {mem_reg[eep_ptr_reg], 8'h00} : ctrl_rd_data);
                if (match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg) != PSMB_TGT_NONE &&
                    !(match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg) == PSMB_TGT_ARA &&
                      !sh_reg[0])) begin
                  st_reg <= ST_ACK_OUT;
                  sda_oe <= 1'b1;
                end else begin
                  st_reg <= ST_IDLE;
                end
              end else begin
                nbyte_reg <= (nbyte_reg == 8'(BLOCK_MAX)) ? nbyte_reg : nbyte_reg + 8'h01;
                if (tgt_reg == PSMB_TGT_EEP) begin
                  eep_ptr_reg <= (nbyte_reg == 8'h01) ? sh_reg : eep_ptr_reg + 8'h01;
                  if (nbyte_reg == 8'h02) eep_data_reg <= sh_reg;  // Kept past STOP's SCL rise
                end else begin
                  if (nbyte_reg == 8'h01) ctrl_cmd <= sh_reg;
                  else ctrl_wr_data <= {sh_reg, ctrl_wr_data[15:8]};
                  ctrl_byte_stb <= 1'b1;
                end
                st_reg <= ST_ACK_OUT;
                sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK_OUT: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (rd_reg) begin
                st_reg  <= ST_TX;
                sda_oe  <= ~tx_word_reg[15];
                sh_reg  <= {tx_word_reg[14:8], 1'b0};
                bit_reg <= 4'h1;
              end else begin
                if (nbyte_reg == 8'h00) nbyte_reg <= 8'h01;
                st_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'h8) begin
                sda_oe <= 1'b0;
                st_reg <= ST_ACK_IN;
              end else begin
                sda_oe  <= ~sh_reg[7];
                sh_reg  <= {sh_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_ACK_IN: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_reg <= ST_IDLE;  // Host NACK ends the read
              end else begin
                // Word reads supply the low byte next
                tx_word_reg <= {tx_word_reg[7:0], 8'h00};
                st_reg      <= ST_ACK_OUT;
              end
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // EEPROM storage, written only on STOP with protection off
  always_ff @(posedge mclk) begin
    if (!sys_rst && stop_c && st_reg != ST_IDLE && tgt_reg == PSMB_TGT_EEP && !rd_reg &&
        nbyte_reg == 8'h03 && !eep_wp) begin
      mem_reg[eep_ptr_reg - 8'h01] <= eep_data_reg;
    end
  end

  // Never stretches, so SCL driver is idle; data line only pulls low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
    end
  end

  // Assertions
  property p_alert;
    @(posedge mclk) disable iff (sys_rst)
      (shutdown_event | warning_event) |=> !fault_alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not asserted");
  property p_nostretch;
    @(posedge mclk) disable iff (sys_rst) !scl_oe;
  endproperty
  a_nostretch: assert property (p_nostretch) else $error("scl driven");
  property p_wp_reset;
    @(posedge mclk) $fell(sys_rst) |-> eep_wp;
  endproperty
  a_wp_reset: assert property (p_wp_reset) else $error("wp not set");
  property p_sel_hold;
    @(posedge mclk) disable iff (sys_rst)
      sel_done_reg && $past(sel_done_reg) |-> $stable(ctrl_addr);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("address changed");
  property p_offset;
    @(posedge mclk) disable iff (sys_rst)
      sel_done_reg |-> (ctrl_addr - eep_addr_reg) == 7'h08;
  endproperty
  a_offset: assert property (p_offset) else $error("eeprom offset wrong");
  property p_stop_idle;
    @(posedge mclk) disable iff (sys_rst) stop_c && !to_evt |=> st_reg == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");
  property p_timeout;
    @(posedge mclk) disable iff (sys_rst) to_evt |=> st_reg == ST_IDLE && bus_timeout;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout ignored");
  property p_nack;
    @(posedge mclk) disable iff (sys_rst)
      st_reg == ST_ADDR && scl_fall && bit_reg == 4'h8 && !start_c && !stop_c &&
      rec_cnt_reg == 25'h0000000 && !to_evt &&
      match_addr(sh_reg[7:1], ctrl_addr, eep_addr_reg) == PSMB_TGT_NONE |=> !sda_oe;
  endproperty
  a_nack: assert property (p_nack) else $error("acked foreign address");
  c_start: cover property (@(posedge mclk) start_c);
  c_wr: cover property (@(posedge mclk) ctrl_wr_stb);
  c_to: cover property (@(posedge mclk) bus_timeout);
endmodule : psmb_target

// [psmb_tb_top.sv]
// Bench for the two-wire target: straps, EEPROM, word protocol, alert, time-out.
// Assumes the host model drives the bus; both lines are pulled up here.
`timescale 1ns/100ps
module psmb_tb_top;
  import psmb_pkg::*;
  `define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    error_cnt++; $display("unexpected %s exp %0h got %0h", nm, exp, got); end end
  typedef struct packed {logic [2:0] sel; logic word; logic [6:0] ca;} psmb_row_t;
  // Shortened time-out and recovery counts keep the run brief
  localparam int unsigned TO_CYC = 200;
  localparam int unsigned RC_CYC = 100;
  logic        mclk = 1'h0, sys_rst, shut, warn, wpc, wps, byte_stb;
  logic [2:0]  sel;
  logic [7:0]  status, d, cmd;
  logic [15:0] rd_data, wdata;
  logic [6:0]  ca;
  logic        scl_o, scl_oe, sda_o, sda_oe, alert_n, word, wp, wr_stb, tmo, h_scl, h_sda, s;
  wire logic   scl_line, sda_line;
  int          error_cnt = 0, samples_checked = 0, wr_cnt = 0, to_cnt = 0, str_cnt = 0;
  int          byte_cnt = 0;
  psmb_row_t   rows [8] = '{'{3'h0, 1'h0, 7'h58}, '{3'h1, 1'h0, 7'h59}, '{3'h2, 1'h0, 7'h5A},
    '{3'h3, 1'h0, 7'h5B}, '{3'h4, 1'h1, 7'h58}, '{3'h5, 1'h1, 7'h59}, '{3'h6, 1'h1, 7'h5A},
    '{3'h7, 1'h1, 7'h5B}};
  // Open-drain resolution: low if any party pulls
  assign scl_line = ~(h_scl | (scl_oe & ~scl_o));
  assign sda_line = ~(h_sda | (sda_oe & ~sda_o));
  always #25 mclk = ~mclk;
  // Count one-cycle pulses so none is missed while the host is busy
  always @(posedge mclk) begin
    if (wr_stb === 1'h1) wr_cnt++;
    if (tmo === 1'h1) to_cnt++;
    if (byte_stb === 1'h1) byte_cnt++;
    // Any SCL drive, or a fixed output not at zero, counts against the block
    if (sys_rst === 1'h0 && (scl_oe !== 1'h0 || scl_o !== 1'h0 || sda_o !== 1'h0)) str_cnt++;
  end
  psmb_target #(.TIMEOUT_CYCLES(TO_CYC), .RECOVER_CYCLES(RC_CYC)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_proto_select(sel),
    .shutdown_event(shut), .warning_event(warn), .status_value(status),
    .eep_wp_clear(wpc), .eep_wp_set(wps), .ctrl_rd_data(rd_data), .fault_alert_n(alert_n),
    .word_register_protocol(word), .ctrl_addr(ca), .eep_wp(wp), .ctrl_wr_stb(wr_stb),
    .ctrl_cmd(cmd), .ctrl_wr_data(wdata), .ctrl_byte_stb(byte_stb), .bus_timeout(tmo));
  // Programming wait shortened; the design commits at the STOP
  psmb_host_model #(.HALF_NS(5000), .GAP_NS(20_000)) u_host (
    .sda_line(sda_line), .scl_low(h_scl), .sda_low(h_sda));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic rst_dut();
    sys_rst = 1'h1;
    tick(2);
    sys_rst = 1'h0;
    tick(2);
  endtask : rst_dut
  // Send one byte and compare the acknowledge seen on the wire
  task automatic wr(input logic [7:0] b, input logic ack);
    logic [7:0] junk;
    u_host.xfer(b, 1'h1, junk, s);
    `CHK("ack", ~ack, s)
  endtask : wr
  // Single-byte EEPROM write at the top location
  task automatic eep_wr(input logic [7:0] v);
    u_host.start();
    wr(8'hA6, 1'h1);
    wr(8'hFF, 1'h1);
    wr(v, 1'h1);
    u_host.stop(1'h1);
  endtask : eep_wr
  // Controller write carrying n data bytes, low byte first
  task automatic ctrl_wr(input int n);
    u_host.start();
    wr(8'hB6, 1'h1);
    wr(8'h3C, 1'h1);
    if (n > 0) wr(8'h34, 1'h1);
    if (n > 1) wr(8'h12, 1'h1);
    u_host.stop(1'h0);
  endtask : ctrl_wr
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (99_000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    // Inputs idle and reset asserted from time zero
    sys_rst = 1'h1;
    {shut, warn, wpc, wps} = 4'h0;
    sel     = 3'h7;
    status  = 8'hA5;
    rd_data = 16'hBEEF;
    // Every strap code, sampled by a fresh reset, then moved to prove it is held
    foreach (rows[i]) begin
      sel = rows[i].sel;
      rst_dut();
      sel = ~sel;
      tick(2);
      `CHK("proto", rows[i].word, word)
      `CHK("ctrl_addr", rows[i].ca, ca)
      u_host.start();
      wr({rows[i].ca - 7'h08, 1'h0}, 1'h1);
      u_host.stop(1'h0);
    end
    sel = 3'h7;
    rst_dut();
    `CHK("wp", 1'h1, wp)
    u_host.start();
    wr(8'hA8, 1'h0);
    u_host.stop(1'h0);
    // Unprotect, write, protect, rejected overwrite, read back
    wpc = 1'h1;
    tick(1);
    wpc = 1'h0;
    tick(1);
    `CHK("wp", 1'h0, wp)
    eep_wr(8'hC3);
    wps = 1'h1;
    tick(1);
    wps = 1'h0;
    eep_wr(8'h00);
    u_host.start();
    wr(8'hA6, 1'h1);
    wr(8'hFF, 1'h1);
    u_host.start();
    wr(8'hA7, 1'h1);
    u_host.xfer(8'hFF, 1'h1, d, s);
    u_host.stop(1'h0);
    `CHK("eep_data", 8'hC3, d)
    // Alert response read with a fresh status, and a write to that address refused
    status = 8'h5A;
    u_host.start();
    wr(8'h19, 1'h1);
    u_host.xfer(8'hFF, 1'h1, d, s);
    u_host.stop(1'h0);
    `CHK("alert_resp", status, d)
    u_host.start();
    wr(8'h18, 1'h0);
    u_host.stop(1'h0);
    // Word write, then a byte-sized write that must not strobe
    ctrl_wr(2);
    `CHK("wr_cnt", 1, wr_cnt)
    `CHK("bytes", 3, byte_cnt)
    `CHK("cmd", 8'h3C, cmd)
    `CHK("wdata", 16'h1234, wdata)
    ctrl_wr(1);
    `CHK("wr_cnt", 1, wr_cnt)
    `CHK("bytes", 5, byte_cnt)
    // Word read through a repeated START, high byte first, with fresh data
    rd_data = 16'h1E87;
    u_host.start();
    wr(8'hB6, 1'h1);
    wr(8'h3C, 1'h1);
    u_host.start();
    wr(8'hB7, 1'h1);
    u_host.xfer(8'hFF, 1'h0, d, s);
    `CHK("rd_hi", rd_data[15:8], d)
    u_host.xfer(8'hFF, 1'h1, d, s);
    `CHK("rd_lo", rd_data[7:0], d)
    u_host.stop(1'h0);
    // STOP in mid-byte, then fresh traffic is answered
    u_host.start();
    repeat (3) u_host.bit_io(1'h1, s);
    u_host.stop(1'h0);
    u_host.start();
    wr(8'hA6, 1'h1);
    u_host.stop(1'h0);
    // SCL held low past the time-out, then recovery
    u_host.start();
    wr(8'hB6, 1'h1);
    tick(TO_CYC + 50);
    `CHK("timeouts", 1, to_cnt)
    tick(RC_CYC);
    u_host.stop(1'h0);
    u_host.start();
    wr(8'hB6, 1'h1);
    u_host.stop(1'h0);
    // Alert is the OR of both event groups
    for (int i = 0; i < 4; i++) begin
      {shut, warn} = i[1:0];
      tick(3);
      `CHK("alert_n", ~(shut | warn), alert_n)
    end
    `CHK("stretch", 0, str_cnt)
    summarize();
  end
endmodule : psmb_tb_top
